// ---- design/tpc_pkg.sv ----
package tpc_pkg;
  // What this block does
  // - Correcting variable spans +100 % heating on output 1 to -100 % cooling on output 2
  // - Direct action only swaps the heating and cooling outputs and the open and close outputs
  // - Separate neutral-zone widths for heating and cooling trigger points
  // - Inside the neutral zone the correcting variable stays frozen
  // - Heating or cooling side chosen from the sign of the control error
  // - Integral time above zero adds integral action, removing lasting offset
  // - Integral time zero gives PD action with lasting offset
  // - Cycle-time parameters are output periods at 50 % duty
  // - Second cycle time is minimum off time in water cooling; default 5 s
  // - Correcting variable and working point clamped to limits, defaults -1000 and 1000
  // - Stepping pulses have 0.1 s resolution and minimum
  // - Stepping hysteresis is half the minimum pulse length
  // - Larger band gives shorter steps, smaller band longer steps
  // - Larger integral time gives longer pauses between steps
  // - Larger derivative time gives larger steps
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_TIME_NS  = 100_000_000;
  localparam int TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int TICKS_PER_SEC = 10;
  localparam int CT_DEFAULT_MS = 5000;
  localparam int CT_DEFAULT    = CT_DEFAULT_MS / 100;
  localparam int DUTY_SCALE    = 1000;
  localparam int STEP_HALF     = DUTY_SCALE / 2;
  localparam int STEP_KEEP     = DUTY_SCALE + STEP_HALF;
  localparam int INT_FRAC      = 8;
  localparam int INT_LIMIT     = 2 * DUTY_SCALE * (2 ** INT_FRAC);
  localparam int DIV_NW        = 48;
  localparam int DIV_DW        = 20;
  localparam logic [9:0] DUTY_FULL = 10'(DUTY_SCALE);
  localparam int NUM_CFG     = 18;
  localparam int IDX_CTRL    = 0;
  localparam int IDX_SETP    = 1;
  localparam int IDX_PROC    = 2;
  localparam int IDX_PB_HEAT = 3;
  localparam int IDX_PB_COOL = 4;
  localparam int IDX_TI_HEAT = 5;
  localparam int IDX_TI_COOL = 6;
  localparam int IDX_TD_HEAT = 7;
  localparam int IDX_TD_COOL = 8;
  localparam int IDX_CT_HEAT = 9;
  localparam int IDX_CT_COOL = 10;
  localparam int IDX_Y_MIN   = 11;
  localparam int IDX_Y_MAX   = 12;
  localparam int IDX_Y_WORK  = 13;
  localparam int IDX_DZ_HEAT = 14;
  localparam int IDX_DZ_COOL = 15;
  localparam int IDX_TRAVEL  = 16;
  localparam int IDX_PULSE   = 17;
  localparam int IDX_STATUS  = 18;
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_DIRECT = 1;
  localparam int CTRL_STEP   = 2;
  localparam int CTRL_WATER  = 3;
  localparam logic [15:0] CFG_RESET [NUM_CFG] = '{
    16'h0000, 16'h0000, 16'h0000, 16'h03e8, 16'h03e8, 16'h000a,
    16'h000a, 16'h000a, 16'h000a, 16'(CT_DEFAULT), 16'(CT_DEFAULT),
    16'hfc18, 16'h03e8, 16'h0000, 16'h0000, 16'h0000, 16'h0258,
    16'h0001};
  typedef enum logic [2:0] {
    ST_IDLE, ST_PROP, ST_INT, ST_DER, ST_SUM
  } tpc_state_t;
endpackage

// ---- design/tpc_divider.sv ----
`timescale 1ns/1ps
module tpc_divider import tpc_pkg::*; (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  // Request
  input  wire logic                     start,
  input  wire logic signed [DIV_NW-1:0] numer,
  input  wire logic        [DIV_DW-1:0] denom,
  // Answer
  output logic                          done,
  output logic signed [DIV_NW-1:0]      quot
);
  logic [DIV_NW-1:0] q_reg;
  logic [DIV_DW:0]   rem_reg;
  logic [DIV_DW-1:0] den_reg;
  logic [5:0]        cnt_reg;
  logic              neg_reg;
  // One quotient bit per clock keeps the datapath to a single subtractor
  wire [DIV_DW:0]   trial  = {rem_reg[DIV_DW-1:0], q_reg[DIV_NW-1]};
  wire              fits   = trial >= {1'b0, den_reg};
  wire [DIV_DW:0]   remNew = fits ? trial - {1'b0, den_reg} : trial;
  wire [DIV_NW-1:0] qNew   = {q_reg[DIV_NW-2:0], fits};
  wire [DIV_NW-1:0] numMag = numer[DIV_NW-1] ? -numer : numer;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q_reg   <= '0;
      rem_reg <= '0;
      den_reg <= '0;
      cnt_reg <= '0;
      neg_reg <= 1'b0;
      done    <= 1'b0;
      quot    <= '0;
    end else begin
      done <= 1'b0;
      if (start) begin
        q_reg   <= numMag;
        rem_reg <= '0;
        den_reg <= denom;
        cnt_reg <= 6'(DIV_NW);
        neg_reg <= numer[DIV_NW-1];
      end else if (cnt_reg != 6'h0) begin
        q_reg   <= qNew;
        rem_reg <= remNew;
        cnt_reg <= cnt_reg - 6'h1;
        if (cnt_reg == 6'h1) begin
          done <= 1'b1;
          quot <= neg_reg ? -qNew : qNew;
        end
      end
    end
  end

  a_div_latency: assert property (@(posedge clk) disable iff (!reset_n)
    start |-> ##49 done)
    else $error("divider answer not 49 cycles after start");
endmodule

// ---- design/tpc_pulse_mod.sv ----
`timescale 1ns/1ps
module tpc_pulse_mod import tpc_pkg::*; (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Tick strobe, water mode, duty in DUTY_SCALE units, and times in 0.1 s ticks
  input  wire logic        tick,
  input  wire logic        water,
  input  wire logic [9:0]  duty,
  input  wire logic [15:0] period,
  input  wire logic [15:0] onLen,
  input  wire logic [15:0] offMin,
  // Drive
  output logic             pulseOut
);
  logic [15:0] phase_reg;
  wire [15:0] phaseInc  = phase_reg + 16'h1;
  wire [31:0] phaseScl  = 32'(phase_reg) * 32'(DUTY_SCALE);
  wire [31:0] onArea    = 32'(duty) * 32'(period);
  wire [31:0] incArea   = 32'(phaseInc) * 32'(duty);
  wire [31:0] onScl     = 32'(onLen) * 32'(DUTY_SCALE);
  // Fixed period: at half duty the output period equals the cycle time
  wire        normEnd   = phaseInc >= period;
  // Fixed on pulse; cycle stretched so the off time never drops below offMin
  wire        waterEnd  = (17'(phaseInc) >= 17'(onLen) + 17'(offMin))
                          && (incArea >= onScl);
  wire        periodEnd = water ? waterEnd : normEnd;
  wire        onNow     = water ? (phase_reg < onLen) : (phaseScl < onArea);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_reg <= '0;
      pulseOut  <= 1'b0;
    end else begin
      if (tick) begin
        phase_reg <= periodEnd ? '0 : phaseInc;
      end
      pulseOut <= (duty != 10'h0) && onNow;
    end
  end

  a_zero_duty: assert property (@(posedge clk) disable iff (!reset_n)
    (duty == 10'h0) |=> !pulseOut)
    else $error("pulse output active with zero duty");
endmodule

// ---- design/tpc_controller.sv ----
// The Wishbone register port and the register offsets were decided locally.
`timescale 1ns/1ps
module tpc_controller import tpc_pkg::*; #(
  parameter int TICK_LEN = TICK_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [6:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Actuator drive
  output logic             heatOut,
  output logic             coolOut,
  output logic             openOut,
  output logic             closeOut
);
  logic [15:0]              cfg_reg [NUM_CFG];
  logic [31:0]              tickCnt_reg;
  logic                     tick_reg;
  tpc_state_t               state_reg;
  tpc_state_t               state_next;
  logic                     divStart_reg;
  logic                     startNext;
  logic signed [16:0]       errCap_reg;
  logic signed [16:0]       errPrev_reg;
  logic                     heatSide_reg;
  logic                     inZone_reg;
  logic signed [DIV_NW-1:0] pTerm_reg;
  logic signed [DIV_NW-1:0] dTerm_reg;
  logic signed [DIV_NW-1:0] integ_reg;
  logic signed [15:0]       yVal_reg;
  logic signed [DIV_NW-1:0] pending_reg;
  logic                     open_reg;
  logic                     close_reg;
  logic                     lastOpen_reg;
  logic [15:0]              gap_reg;
  logic                     divDone;
  logic signed [DIV_NW-1:0] divQuot;
  logic                     heatRaw;
  logic                     coolRaw;

  // Bus decode
  wire [4:0]  regIdx = wb_adr_i[6:2];
  wire        busReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire        busWr  = busReq && wb_we_i;
  wire        isCfg  = regIdx < 5'(NUM_CFG);
  wire        isStat = regIdx == 5'(IDX_STATUS);
  wire [31:0] statusW = {11'h0, closeOut, openOut, coolOut, heatOut,
                         inZone_reg, yVal_reg};
  wire [31:0] rdData = isCfg ? {16'h0, cfg_reg[regIdx]} :
                       isStat ? statusW : 32'h0;

  // Settings
  wire        enable   = cfg_reg[IDX_CTRL][CTRL_ENABLE];
  wire        direct   = cfg_reg[IDX_CTRL][CTRL_DIRECT];
  wire        stepMode = cfg_reg[IDX_CTRL][CTRL_STEP];
  wire        waterOn  = cfg_reg[IDX_CTRL][CTRL_WATER];
  wire signed [15:0] setPoint = $signed(cfg_reg[IDX_SETP]);
  wire signed [15:0] procVal  = $signed(cfg_reg[IDX_PROC]);
  wire signed [15:0] yMin     = $signed(cfg_reg[IDX_Y_MIN]);
  wire signed [15:0] yMax     = $signed(cfg_reg[IDX_Y_MAX]);
  wire signed [15:0] yWork    = $signed(cfg_reg[IDX_Y_WORK]);
  wire [15:0] ctHeat = cfg_reg[IDX_CT_HEAT];
  wire [15:0] ctCool = cfg_reg[IDX_CT_COOL];
  wire [15:0] pulseV = cfg_reg[IDX_PULSE];
  wire [15:0] travel = cfg_reg[IDX_TRAVEL];

  // Control error and neutral zone
  wire signed [16:0] errW = 17'(setPoint) - 17'(procVal);
  wire signed [16:0] dzHi = {1'b0, cfg_reg[IDX_DZ_HEAT]};
  wire signed [16:0] dzLo = -$signed({1'b0, cfg_reg[IDX_DZ_COOL]});
  wire        inZoneW  = (errW <= dzHi) && (errW >= dzLo);
  wire        heatSide = errW > 17'sh0;

  // Parameter set of the active side
  wire [15:0] band   = heatSide_reg ? cfg_reg[IDX_PB_HEAT]
                                    : cfg_reg[IDX_PB_COOL];
  wire [15:0] tiSel  = heatSide_reg ? cfg_reg[IDX_TI_HEAT]
                                    : cfg_reg[IDX_TI_COOL];
  wire [15:0] tdSel  = heatSide_reg ? cfg_reg[IDX_TD_HEAT]
                                    : cfg_reg[IDX_TD_COOL];
  // A zero band would divide by zero; treat it as the finest band
  wire [15:0] bandNz = (band == 16'h0) ? 16'h1 : band;

  // Divider operands per phase
  wire signed [DIV_NW-1:0] numProp = DIV_NW'(errCap_reg)
                                     * DIV_NW'(DUTY_SCALE);
  wire signed [DIV_NW-1:0] numInt  = pTerm_reg <<< INT_FRAC;
  wire signed [DIV_NW-1:0] errDiff = DIV_NW'(errCap_reg)
                                     - DIV_NW'(errPrev_reg);
  wire signed [DIV_NW-1:0] numDer  = errDiff
                                     * DIV_NW'($signed({1'b0, tdSel}))
                                     * DIV_NW'(TICKS_PER_SEC
                                               * DUTY_SCALE);
  wire signed [DIV_NW-1:0] numerW  = (state_reg == ST_PROP) ? numProp :
                                     (state_reg == ST_INT) ? numInt :
                                     numDer;
  wire [DIV_DW-1:0] denomW = (state_reg == ST_INT)
                             ? DIV_DW'(tiSel) * DIV_DW'(TICKS_PER_SEC)
                             : DIV_DW'(bandNz);

  function automatic logic signed [DIV_NW-1:0] clampS(
    input logic signed [DIV_NW-1:0] v,
    input logic signed [DIV_NW-1:0] lo,
    input logic signed [DIV_NW-1:0] hi);
    clampS = (v < lo) ? lo : (v > hi) ? hi : v;
  endfunction

  // Sum and limits
  wire signed [DIV_NW-1:0] y0Eff  = clampS(DIV_NW'(yWork), DIV_NW'(yMin),
                                           DIV_NW'(yMax));
  wire signed [DIV_NW-1:0] intLim = DIV_NW'(INT_LIMIT);
  wire signed [DIV_NW-1:0] integNext = clampS(integ_reg + divQuot,
                                              -intLim, intLim);
  wire signed [DIV_NW-1:0] sumW   = y0Eff + pTerm_reg
                                    + (integ_reg >>> INT_FRAC) + dTerm_reg;
  wire signed [DIV_NW-1:0] yClamp = clampS(sumW, DIV_NW'(yMin),
                                           DIV_NW'(yMax));
  wire signed [15:0] yNext = yClamp[15:0];

  // Stepping: travel demand in tick*DUTY_SCALE units
  wire signed [DIV_NW-1:0] dyScaled = (DIV_NW'(yNext) - DIV_NW'(yVal_reg))
                                      * DIV_NW'($signed({1'b0, travel}));
  wire signed [DIV_NW-1:0] addDem   = (state_reg == ST_SUM)
                                      ? dyScaled : '0;
  wire signed [DIV_NW-1:0] runOff   = !tick_reg ? '0 :
                                      open_reg ? -DIV_NW'(DUTY_SCALE) :
                                      close_reg ? DIV_NW'(DUTY_SCALE) : '0;
  wire signed [DIV_NW-1:0] pendNext = (stepMode && enable)
                                      ? pending_reg + addDem + runOff
                                      : '0;
  wire [15:0] pulseNz = (pulseV == 16'h0) ? 16'h1 : pulseV;
  wire signed [DIV_NW-1:0] stepThr  = DIV_NW'($signed({1'b0, pulseNz}))
                                      * DIV_NW'(STEP_HALF);
  wire signed [DIV_NW-1:0] keepThr  = DIV_NW'(STEP_KEEP);
  // A reversal waits ctCool ticks to spare the motor and its contactors
  wire        revOk     = gap_reg == 16'h0;
  wire        openGo    = (pending_reg >= stepThr)
                          && (lastOpen_reg || revOk);
  wire        closeGo   = (pending_reg <= -stepThr)
                          && (!lastOpen_reg || revOk);
  wire        openNext  = open_reg ? (pending_reg >= keepThr)
                                   : (openGo && !close_reg);
  wire        closeNext = close_reg ? (pending_reg <= -keepThr)
                                    : (closeGo && !open_reg);
  wire        stepEnd   = (open_reg && !openNext)
                          || (close_reg && !closeNext);

  // Duty-cycle outputs
  wire [15:0] yMag    = yVal_reg[15] ? 16'(-yVal_reg) : 16'(yVal_reg);
  wire [9:0]  dutyMag = (yMag > 16'(DUTY_FULL)) ? DUTY_FULL : yMag[9:0];
  wire        pwmOn   = enable && !stepMode;
  wire [9:0]  dutyHt  = (pwmOn && !yVal_reg[15]) ? dutyMag : 10'h0;
  wire [9:0]  dutyCl  = (pwmOn && yVal_reg[15]) ? dutyMag : 10'h0;
  wire        heatSel = direct ? coolRaw : heatRaw;
  wire        coolSel = direct ? heatRaw : coolRaw;
  wire        openSel = direct ? close_reg : open_reg;
  wire        clsSel  = direct ? open_reg : close_reg;

  genvar g;
  generate
    for (g = 0; g < NUM_CFG; g++) begin : gCfg
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          cfg_reg[g] <= CFG_RESET[g];
        end else if (busWr && regIdx == 5'(g)) begin
          if (wb_sel_i[0]) cfg_reg[g][7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) cfg_reg[g][15:8] <= wb_dat_i[15:8];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= busReq;
      wb_dat_o <= busReq ? rdData : 32'h0;
    end
  end

  wire tickWrap = tickCnt_reg >= 32'(TICK_LEN - 1);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tickCnt_reg <= 32'h0;
      tick_reg    <= 1'b0;
    end else begin
      tickCnt_reg <= tickWrap ? 32'h0 : tickCnt_reg + 32'h1;
      tick_reg    <= tickWrap;
    end
  end

  always_comb begin
    state_next = state_reg;
    startNext  = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (tick_reg && enable && !inZoneW) begin
          state_next = ST_PROP;
          startNext  = 1'b1;
        end
      end
      ST_PROP: begin
        if (divDone) begin
          state_next = (tiSel != 16'h0) ? ST_INT : ST_DER;
          startNext  = 1'b1;
        end
      end
      ST_INT: begin
        if (divDone) begin
          state_next = ST_DER;
          startNext  = 1'b1;
        end
      end
      ST_DER: begin
        if (divDone) begin
          state_next = ST_SUM;
        end
      end
      ST_SUM: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  tpc_divider uDiv (
    .clk     (clk),
    .reset_n (reset_n),
    .start   (divStart_reg),
    .numer   (numerW),
    .denom   (denomW),
    .done    (divDone),
    .quot    (divQuot)
  );

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg    <= ST_IDLE;
      divStart_reg <= 1'b0;
      errCap_reg   <= '0;
      errPrev_reg  <= '0;
      heatSide_reg <= 1'b0;
      inZone_reg   <= 1'b0;
    end else begin
      state_reg    <= state_next;
      divStart_reg <= startNext;
      if (tick_reg) begin
        errCap_reg   <= errW;
        errPrev_reg  <= errCap_reg;
        heatSide_reg <= heatSide;
        inZone_reg   <= inZoneW;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pTerm_reg <= '0;
      integ_reg <= '0;
      dTerm_reg <= '0;
      yVal_reg  <= '0;
    end else begin
      if (divDone && state_reg == ST_PROP) begin
        pTerm_reg <= divQuot;
      end
      if (divDone && state_reg == ST_PROP && tiSel == 16'h0) begin
        integ_reg <= '0;
      end
      if (divDone && state_reg == ST_INT) begin
        integ_reg <= integNext;
      end
      if (divDone && state_reg == ST_DER) begin
        dTerm_reg <= divQuot;
      end
      if (state_reg == ST_SUM) begin
        yVal_reg <= yNext;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pending_reg  <= '0;
      open_reg     <= 1'b0;
      close_reg    <= 1'b0;
      lastOpen_reg <= 1'b0;
      gap_reg      <= 16'h0;
    end else begin
      pending_reg <= pendNext;
      if (!(stepMode && enable)) begin
        open_reg  <= 1'b0;
        close_reg <= 1'b0;
      end else if (tick_reg) begin
        open_reg  <= openNext;
        close_reg <= closeNext;
        if (openNext) lastOpen_reg <= 1'b1;
        if (closeNext) lastOpen_reg <= 1'b0;
        if (stepEnd) gap_reg <= ctCool;
        else if (gap_reg != 16'h0) gap_reg <= gap_reg - 16'h1;
      end
    end
  end

  tpc_pulse_mod uHeat (
    .clk      (clk),
    .reset_n  (reset_n),
    .tick     (tick_reg),
    .water    (1'b0),
    .duty     (dutyHt),
    .period   (ctHeat),
    .onLen    (pulseV),
    .offMin   (ctCool),
    .pulseOut (heatRaw)
  );

  tpc_pulse_mod uCool (
    .clk      (clk),
    .reset_n  (reset_n),
    .tick     (tick_reg),
    .water    (waterOn),
    .duty     (dutyCl),
    .period   (ctCool),
    .onLen    (pulseV),
    .offMin   (ctCool),
    .pulseOut (coolRaw)
  );

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      heatOut  <= 1'b0;
      coolOut  <= 1'b0;
      openOut  <= 1'b0;
      closeOut <= 1'b0;
    end else begin
      heatOut  <= heatSel && !coolSel;
      coolOut  <= coolSel && !heatSel;
      openOut  <= openSel && !clsSel;
      closeOut <= clsSel && !openSel;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  a_out_exclusive: assert property (
    !(heatOut && coolOut) && !(openOut && closeOut))
    else $error("opposing outputs active together");
  a_heat_side: assert property (
    heatOut |-> ($past(direct) ? $past(yVal_reg, 2) < 0
                               : $past(yVal_reg, 2) > 0))
    else $error("heat output on wrong sign");
  a_cool_side: assert property (
    coolOut |-> ($past(direct) ? $past(yVal_reg, 2) > 0
                               : $past(yVal_reg, 2) < 0))
    else $error("cool output on wrong sign");
  a_y_limits: assert property (
    (state_reg == ST_SUM && yMin <= yMax)
    |=> (yVal_reg >= yMin && yVal_reg <= yMax))
    else $error("correcting variable outside limits");
  a_zone_freeze: assert property (
    (state_reg == ST_IDLE && tick_reg && inZoneW)
    |=> (state_reg == ST_IDLE && $stable(yVal_reg)))
    else $error("update started inside neutral zone");
  a_zone_side: assert property (
    (tick_reg && !inZoneW && errW > 17'sh0) |=> heatSide_reg)
    else $error("heating side not selected");
  a_int_path: assert property (
    (state_reg == ST_PROP && divDone && tiSel != 16'h0)
    |=> state_reg == ST_INT)
    else $error("integral step skipped");
  a_pd_no_int: assert property (
    (state_reg == ST_PROP && divDone && tiSel == 16'h0)
    |=> (integ_reg == 0 && state_reg == ST_DER))
    else $error("integral kept with zero integral time");
  a_step_tick: assert property (
    ($rose(open_reg) || $rose(close_reg)) |-> $past(tick_reg))
    else $error("step pulse started off the tick grid");
  a_step_thr: assert property (
    $rose(open_reg) |-> $past(pending_reg >= stepThr))
    else $error("step pulse below hysteresis");

  c_zone_hold: cover property (tick_reg && inZoneW && enable);
  c_heat_on: cover property ($rose(heatOut));
  c_cool_on: cover property ($rose(coolOut));
  c_step_open: cover property ($rose(openOut) ##[1:300] !openOut);
endmodule

// ---- bench/tpc_actuator_model.sv ----
`timescale 1ns/1ps
module tpc_actuator_model (
  // Clock and count clear
  input  wire logic clk,
  input  wire logic clr,
  // Drives seen
  input  wire logic heatOut,
  input  wire logic coolOut,
  input  wire logic openOut,
  input  wire logic closeOut,
  // On-time counts and opposing-drive clash count, in clock cycles
  output int        heatCnt,
  output int        coolCnt,
  output int        openCnt,
  output int        closeCnt,
  output int        clashCnt
);
  // Relays and valve motor only integrate on-time; no feedback to the block
  always @(posedge clk) begin
    if (clr) begin
      heatCnt <= 0;
      coolCnt <= 0;
      openCnt <= 0;
      closeCnt <= 0;
    end else begin
      heatCnt <= heatCnt + int'(heatOut === 1'b1);
      coolCnt <= coolCnt + int'(coolOut === 1'b1);
      openCnt <= openCnt + int'(openOut === 1'b1);
      closeCnt <= closeCnt + int'(closeOut === 1'b1);
    end
    // Opposing drives at once would short the motor or fight the loads
    clashCnt <= clashCnt + int'((heatOut & coolOut) | (openOut & closeOut));
  end
endmodule

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import tpc_pkg::*;
  localparam int TL = 200;
  logic        clk, resetN, cyc, stb, we, clr;
  logic [6:0]  adr;
  logic [31:0] dat, datO, r;
  logic        ack, heat, cool, opn, cls;
  int          nErrors, checksDone, cycCnt, hc, cc, oc, kc, xc, y1;
  tpc_controller #(.TICK_LEN(TL)) tpc_controller_inst (.clk(clk),
    .reset_n(resetN), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat), .wb_dat_o(datO),
    .wb_ack_o(ack), .heatOut(heat), .coolOut(cool), .openOut(opn),
    .closeOut(cls));
  tpc_actuator_model tpc_actuator_model_inst (.clk(clk), .clr(clr),
    .heatOut(heat), .coolOut(cool), .openOut(opn), .closeOut(cls),
    .heatCnt(hc), .coolCnt(cc), .openCnt(oc), .closeCnt(kc),
    .clashCnt(xc));
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  task automatic stopTest();
    if (nErrors == 0 && checksDone > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cycCnt++;
    if (cycCnt == 60000) begin
      nErrors++;
      stopTest();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checksDone++;
    if (seen !== exp) begin
      nErrors++;
      $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
    end
  endtask
  // Classic single cycle; hold everything until ack is sampled
  task automatic wb(input logic w, input logic [6:0] a, input int d);
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= 32'(d);
    do @(posedge clk); while (ack !== 1'b1);
    r = datO;
    cyc <= 0;
    stb <= 0;
    we <= 0;
  endtask
  task automatic run(input int n);
    clr <= 1;
    @(posedge clk);
    clr <= 0;
    repeat (n * TL) @(posedge clk);
    wb(0, 7'h48, 0);
  endtask
  initial begin
    {nErrors, checksDone, cycCnt} = 0;
    {cyc, stb, we, clr, resetN} = 0;
    adr = 0;
    dat = 0;
    repeat (16) @(posedge clk);
    resetN <= 1;
    for (int i = 0; i < NUM_CFG; i++) begin
      wb(0, 7'(4 * i), 0);
      chk(r[15:0], CFG_RESET[i]);
    end
    wb(1, 7'h60, 16'h1234);
    wb(0, 7'h60, 0);
    chk(r[15:0], 16'h0);
    for (int i = 5; i <= 8; i++) wb(1, 7'(4 * i), 0);
    wb(1, 7'h24, 2);
    wb(1, 7'h28, 2);
    wb(1, 7'h04, 100);
    wb(1, 7'h00, 1);
    run(6);
    chk(r[15:0], 16'h0064);
    chk(16'(hc > 0), 16'h1);
    chk(16'(cc), 16'h0);
    wb(1, 7'h00, 3);
    run(6);
    chk(r[15:0], 16'h0064);
    chk(16'(hc), 16'h0);
    chk(16'(cc > 0), 16'h1);
    wb(1, 7'h00, 1);
    wb(1, 7'h0c, 2000);
    run(3);
    chk(r[15:0], 16'h0032);
    wb(1, 7'h04, -100);
    run(6);
    chk(r[15:0], 16'hff9c);
    chk(16'(cc > 0), 16'h1);
    wb(1, 7'h30, 300);
    wb(1, 7'h04, 1000);
    run(3);
    chk(r[15:0], 16'h012c);
    wb(1, 7'h30, 1000);
    wb(1, 7'h04, 100);
    wb(1, 7'h14, 1);
    run(4);
    chk(16'($signed(r[15:0]) > 50), 16'h1);
    wb(1, 7'h38, 200);
    run(2);
    y1 = int'(r[15:0]);
    chk(16'(r[16]), 16'h1);
    run(4);
    chk(r[15:0], 16'(y1));
    wb(1, 7'h40, 10);
    wb(1, 7'h38, 0);
    wb(1, 7'h00, 5);
    run(30);
    chk(16'(oc >= TL), 16'h1);
    chk(16'(kc), 16'h0);
    // Water cooling: one-tick pulse per stretched cycle, far below plain duty
    wb(1, 7'h00, 9);
    wb(1, 7'h04, -100);
    run(20);
    chk(r[15:0], 16'hff9c);
    chk(16'(cc >= TL && cc < 5 * TL), 16'h1);
    chk(16'(xc), 16'h0);
    stopTest();
  end
endmodule
